// *** core/llm_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the lock-loss monitor
`ifndef LLM_REGS_SVH
`define LLM_REGS_SVH

// Word indices; each register takes one aligned word at a byte address four times the printed index
`define LLM_IDX_LIVE 8'h0e
`define LLM_IDX_STICKY 8'h13
`define LLM_IDX_MASK 8'h19
`define LLM_IDX_FAST_EN 8'h92
`define LLM_IDX_SET_THR 8'h9e
`define LLM_IDX_CLR_THR 8'ha0
`define LLM_IDX_TIMER_EN 8'ha2
`define LLM_IDX_DLY0 8'ha9
`define LLM_IDX_DLY1 8'haa
`define LLM_IDX_DLY2 8'hab
`define LLM_IDX_DLY3 8'hac
`define LLM_IDX_WINDOW 8'hb0

// Field positions
`define LLM_BIT_LIVE 1
`define LLM_BIT_STICKY 1
`define LLM_BIT_MASK 1
`define LLM_BIT_FAST_EN 1
`define LLM_BIT_TIMER_EN 1
`define LLM_THR_LSB 4

// Reset values
`define LLM_RST_MASK 1'b0
`define LLM_RST_FAST_EN 1'b1
`define LLM_RST_TIMER_EN 1'b0
`define LLM_RST_SET_THR 4'h2
`define LLM_RST_CLR_THR 4'h0
`define LLM_RST_DLY 29'h0000100
`define LLM_RST_WINDOW 32'd100000

// Clear-delay unit: 4 ns per count, ticks derived from the 10 ns clock period
`define LLM_DLY_UNIT_PS 4000
`define LLM_CLK_PERIOD_PS 10000
// Fast detector threshold factor over the set threshold
`define LLM_FAST_FACTOR 100
`endif

// *** core/llm_pkg.sv ***
// Types of the lock-loss monitor
package llm_pkg;
   typedef enum logic [1:0] {
      LLM_LOCKED,
      LLM_LOST,
      LLM_HOLD
   } llm_state_type;

   typedef struct packed {
      logic mask;
      logic fast_en;
      logic timer_en;
      logic [3:0] set_thr;
      logic [3:0] clr_thr;
      logic [28:0] delay;
      logic [31:0] window;
   } llm_cfg_type;
endpackage

// *** core/llm_monitor.sv ***
// Loss-of-lock monitor with Wishbone registers, hysteresis, fast path and clear delay
// How it works
// - Live bit set when loop loses input lock
// - Counts input and feedback edges, compares difference
// - Lock-loss pin follows live state, active low
// - Live bit live; sticky latches until cleared
// - Fast detector threshold is hundred times set
// - Sensitivity programmable from 1 to 10000 ppm
// - Set above set threshold, clear below clear
// - Four-bit set threshold selects ppm table
// - Four-bit clear threshold selects ppm table
// - Clear delay holds lock loss after clearing
// - Timer enable bit: zero off, one on
// - 29-bit clear delay in 4 ns units
// - Lock loss drives quick-acquisition output
// - Fast path enable, default on
// - Live bit reads one when not locked
// - Sticky cleared by writing zero if live clear
// - Mask bit one ignores lock loss for interrupt
// - Interrupt released only when sticky cleared or masked
`include "llm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module llm_monitor
   import llm_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter int IRQ_SRCS = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic ref_edge,
   input wire logic fb_edge,
   input wire logic [IRQ_SRCS-1:0] other_irq,
   output logic lock_loss_pin_n,
   output logic irq_pin_n,
   output logic fastlock_en
);

   // Per-tick cycles of the 4 ns delay unit, scaled by 1000 to keep precision
   localparam longint DLY_NUM = `LLM_DLY_UNIT_PS;
   localparam longint DLY_DEN = `LLM_CLK_PERIOD_PS;

   // Set-threshold ppm table, scaled by ten (0.1 ppm units)
   function automatic logic [19:0] set_ppm10(input logic [3:0] code);
      case (code)
         4'h0: set_ppm10 = 20'd10;
         4'h1: set_ppm10 = 20'd30;
         4'h2: set_ppm10 = 20'd100;
         4'h3: set_ppm10 = 20'd300;
         4'h4: set_ppm10 = 20'd1000;
         4'h5: set_ppm10 = 20'd3000;
         4'h6: set_ppm10 = 20'd10000;
         4'h7: set_ppm10 = 20'd30000;
         default: set_ppm10 = 20'd100000;
      endcase
   endfunction

   // Clear-threshold ppm table, scaled by ten
   function automatic logic [19:0] clr_ppm10(input logic [3:0] code);
      case (code)
         4'h0: clr_ppm10 = 20'd1;
         4'h1: clr_ppm10 = 20'd3;
         4'h2: clr_ppm10 = 20'd10;
         4'h3: clr_ppm10 = 20'd30;
         4'h4: clr_ppm10 = 20'd100;
         4'h5: clr_ppm10 = 20'd300;
         4'h6: clr_ppm10 = 20'd1000;
         4'h7: clr_ppm10 = 20'd3000;
         4'h8: clr_ppm10 = 20'd10000;
         4'h9: clr_ppm10 = 20'd30000;
         default: clr_ppm10 = 20'd100000;
      endcase
   endfunction

   // Error in 0.1 ppm over a window of n reference edges exceeds limit
   function automatic logic over(input logic [CNT_W-1:0] diff, input logic [CNT_W-1:0] n,
                                 input logic [26:0] lim10);
      // Widened to 64 bits so that the product cannot wrap for any window
      over = 64'(diff) * 64'd10000000 > 64'(n) * 64'(lim10);
   endfunction

   llm_cfg_type cfg_reg;
   logic lock_loss_reg;
   logic sticky_reg;
   logic [CNT_W-1:0] ref_cnt_reg;
   logic [CNT_W-1:0] fb_cnt_reg;
   logic [CNT_W-1:0] fast_win_reg;
   logic [CNT_W-1:0] diff_reg;
   logic [CNT_W-1:0] diff_n_reg;
   logic meas_done_reg;
   logic [CNT_W-1:0] ffb_reg;
   logic fast_trip_reg;
   logic [37:0] hold_reg;
   llm_state_type state_reg;
   logic [31:0] wb_dat_reg;
   logic wb_ack_reg;
   logic wb_err_reg;
   logic pin_n_reg;
   logic irq_n_reg;
   logic fastlock_reg;

   // Bus decode
   wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_reg & ~wb_err_reg;
   wire logic wr = req & wb_we_i & wb_sel_i[0];
   wire logic [9:0] idx = wb_adr_i[11:2];
   wire logic hit_live = idx == {2'b00, `LLM_IDX_LIVE};
   wire logic hit_sticky = idx == {2'b00, `LLM_IDX_STICKY};
   wire logic hit_mask = idx == {2'b00, `LLM_IDX_MASK};
   wire logic hit_fast = idx == {2'b00, `LLM_IDX_FAST_EN};
   wire logic hit_set = idx == {2'b00, `LLM_IDX_SET_THR};
   wire logic hit_clr = idx == {2'b00, `LLM_IDX_CLR_THR};
   wire logic hit_ten = idx == {2'b00, `LLM_IDX_TIMER_EN};
   wire logic hit_d0 = idx == {2'b00, `LLM_IDX_DLY0};
   wire logic hit_d1 = idx == {2'b00, `LLM_IDX_DLY1};
   wire logic hit_d2 = idx == {2'b00, `LLM_IDX_DLY2};
   wire logic hit_d3 = idx == {2'b00, `LLM_IDX_DLY3};
   wire logic hit_win = idx == {2'b00, `LLM_IDX_WINDOW};
   wire logic hit_any = hit_live | hit_sticky | hit_mask | hit_fast | hit_set | hit_clr |
                        hit_ten | hit_d0 | hit_d1 | hit_d2 | hit_d3 | hit_win;
   wire logic [31:0] rd_data;
   assign rd_data = hit_live ? 32'(lock_loss_reg) << `LLM_BIT_LIVE :
                    hit_sticky ? 32'(sticky_reg) << `LLM_BIT_STICKY :
                    hit_mask ? 32'(cfg_reg.mask) << `LLM_BIT_MASK :
                    hit_fast ? 32'(cfg_reg.fast_en) << `LLM_BIT_FAST_EN :
                    hit_set ? 32'(cfg_reg.set_thr) << `LLM_THR_LSB :
                    hit_clr ? 32'(cfg_reg.clr_thr) << `LLM_THR_LSB :
                    hit_ten ? 32'(cfg_reg.timer_en) << `LLM_BIT_TIMER_EN :
                    hit_d0 ? {24'h0, cfg_reg.delay[7:0]} :
                    hit_d1 ? {24'h0, cfg_reg.delay[15:8]} :
                    hit_d2 ? {24'h0, cfg_reg.delay[23:16]} :
                    hit_d3 ? {27'h0, cfg_reg.delay[28:24]} :
                    hit_win ? cfg_reg.window : 32'h0;

   // Software clear of sticky only when live indicator is low
   wire logic sticky_clr = wr & hit_sticky & ~wb_dat_i[`LLM_BIT_STICKY] & ~lock_loss_reg;

   // Bus answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wb_ack_reg <= 1'b0;
         wb_err_reg <= 1'b0;
         wb_dat_reg <= 32'h0;
      end else begin
         wb_ack_reg <= req & hit_any;
         wb_err_reg <= req & ~hit_any;
         wb_dat_reg <= (req & ~wb_we_i & hit_any) ? rd_data : 32'h0;
      end
   end

   // Configuration registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg_reg.mask <= `LLM_RST_MASK;
         cfg_reg.fast_en <= `LLM_RST_FAST_EN;
         cfg_reg.timer_en <= `LLM_RST_TIMER_EN;
         cfg_reg.set_thr <= `LLM_RST_SET_THR;
         cfg_reg.clr_thr <= `LLM_RST_CLR_THR;
         cfg_reg.delay <= `LLM_RST_DLY;
         cfg_reg.window <= `LLM_RST_WINDOW;
      end else if (wr) begin
         if (hit_mask) cfg_reg.mask <= wb_dat_i[`LLM_BIT_MASK];
         if (hit_fast) cfg_reg.fast_en <= wb_dat_i[`LLM_BIT_FAST_EN];
         if (hit_ten) cfg_reg.timer_en <= wb_dat_i[`LLM_BIT_TIMER_EN];
         if (hit_set) cfg_reg.set_thr <= wb_dat_i[`LLM_THR_LSB +: 4];
         if (hit_clr) cfg_reg.clr_thr <= wb_dat_i[`LLM_THR_LSB +: 4];
         if (hit_d0) cfg_reg.delay[7:0] <= wb_dat_i[7:0];
         if (hit_d1) cfg_reg.delay[15:8] <= wb_dat_i[7:0];
         if (hit_d2) cfg_reg.delay[23:16] <= wb_dat_i[7:0];
         if (hit_d3) cfg_reg.delay[28:24] <= wb_dat_i[4:0];
         if (hit_win && wb_dat_i != 32'h0 && wb_sel_i == 4'hf) cfg_reg.window <= wb_dat_i;
      end
   end

   // Edge counting over a window of reference edges
   wire logic [CNT_W-1:0] win_n = CNT_W'(cfg_reg.window);
   wire logic [CNT_W-1:0] fast_n = CNT_W'(cfg_reg.window / `LLM_FAST_FACTOR) | CNT_W'(1);
   wire logic win_end = ref_edge & (ref_cnt_reg >= win_n - CNT_W'(1));
   wire logic fast_end = ref_edge & (fast_win_reg >= fast_n - CNT_W'(1));
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_cnt_reg <= '0;
         fb_cnt_reg <= '0;
         fast_win_reg <= '0;
         ffb_reg <= '0;
         diff_reg <= '0;
         diff_n_reg <= '0;
         meas_done_reg <= 1'b0;
         fast_trip_reg <= 1'b0;
      end else begin
         // Precise window: frequency difference of input vs feedback
         meas_done_reg <= win_end;
         if (win_end) begin
            diff_reg <= (fb_cnt_reg + CNT_W'(fb_edge) > ref_cnt_reg + CNT_W'(1)) ?
                        fb_cnt_reg + CNT_W'(fb_edge) - ref_cnt_reg - CNT_W'(1) :
                        ref_cnt_reg + CNT_W'(1) - fb_cnt_reg - CNT_W'(fb_edge);
            diff_n_reg <= ref_cnt_reg + CNT_W'(1);
            ref_cnt_reg <= '0;
            fb_cnt_reg <= '0;
         end else begin
            ref_cnt_reg <= ref_cnt_reg + CNT_W'(ref_edge);
            fb_cnt_reg <= fb_cnt_reg + CNT_W'(fb_edge);
         end
         // Short window with hundredfold threshold
         if (fast_end) begin
            fast_trip_reg <= over((ffb_reg + CNT_W'(fb_edge) > fast_win_reg + CNT_W'(1)) ?
                                  ffb_reg + CNT_W'(fb_edge) - fast_win_reg - CNT_W'(1) :
                                  fast_win_reg + CNT_W'(1) - ffb_reg - CNT_W'(fb_edge),
                                  fast_win_reg + CNT_W'(1),
                                  27'(set_ppm10(cfg_reg.set_thr)) * 27'(`LLM_FAST_FACTOR));
            fast_win_reg <= '0;
            ffb_reg <= '0;
         end else begin
            fast_trip_reg <= 1'b0;
            fast_win_reg <= fast_win_reg + CNT_W'(ref_edge);
            ffb_reg <= ffb_reg + CNT_W'(fb_edge);
         end
      end
   end

   // Hysteresis comparators
   wire logic slow_set = meas_done_reg & over(diff_reg, diff_n_reg,
                                              27'(set_ppm10(cfg_reg.set_thr)));
   wire logic slow_clr = meas_done_reg & ~over(diff_reg, diff_n_reg,
                                               27'(clr_ppm10(cfg_reg.clr_thr)) - 27'(1));
   wire logic fast_set = fast_trip_reg & cfg_reg.fast_en;
   wire logic assert_evt = slow_set | fast_set;
   // Delay in clock cycles, rounded up; zero when the delay is zero
   wire logic [37:0] hold_cycles = 38'(({9'h0, cfg_reg.delay} * DLY_NUM + DLY_DEN - 1) / DLY_DEN);

   // Lock-loss state machine with optional clear delay
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= LLM_LOST;
         lock_loss_reg <= 1'b1;
         hold_reg <= '0;
      end else begin
         case (state_reg)
            LLM_LOCKED: begin
               if (assert_evt) begin
                  state_reg <= LLM_LOST;
                  lock_loss_reg <= 1'b1;
               end
            end
            LLM_LOST: begin
               if (slow_clr && !assert_evt) begin
                  if (cfg_reg.timer_en && hold_cycles != 38'h0) begin
                     state_reg <= LLM_HOLD;
                     hold_reg <= hold_cycles;
                  end else begin
                     state_reg <= LLM_LOCKED;
                     lock_loss_reg <= 1'b0;
                  end
               end
            end
            LLM_HOLD: begin
               if (assert_evt) begin
                  state_reg <= LLM_LOST;
               end else if (hold_reg <= 38'h1) begin
                  state_reg <= LLM_LOCKED;
                  lock_loss_reg <= 1'b0;
               end else begin
                  hold_reg <= hold_reg - 38'h1;
               end
            end
            default: state_reg <= LLM_LOST;
         endcase
      end
   end

   // Sticky flag: a new assertion beats a software clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sticky_reg <= 1'b0;
      end else if (lock_loss_reg) begin
         sticky_reg <= 1'b1;
      end else if (sticky_clr) begin
         sticky_reg <= 1'b0;
      end
   end

   // Output pins
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_n_reg <= 1'b0;
         irq_n_reg <= 1'b1;
         fastlock_reg <= 1'b0;
      end else begin
         pin_n_reg <= ~lock_loss_reg;
         irq_n_reg <= ~((sticky_reg & ~cfg_reg.mask) | (|other_irq));
         fastlock_reg <= lock_loss_reg;
      end
   end

   assign wb_dat_o = wb_dat_reg;
   assign wb_ack_o = wb_ack_reg;
   assign wb_err_o = wb_err_reg;
   assign lock_loss_pin_n = pin_n_reg;
   assign irq_pin_n = irq_n_reg;
   assign fastlock_en = fastlock_reg;

endmodule

`default_nettype wire

// *** tb/llm_monitor_asserts.sv ***
// Port-level checks of the lock-loss monitor
`timescale 1ns/1ps
`default_nettype none
module llm_monitor_asserts
   import llm_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter int IRQ_SRCS = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic ref_edge,
   input wire logic fb_edge,
   input wire logic [IRQ_SRCS-1:0] other_irq,
   input wire logic lock_loss_pin_n,
   input wire logic irq_pin_n,
   input wire logic fastlock_en
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // A request with no answer outstanding
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   // Bus answer timing and data
   a_bus_answer: assert property (s_req |=> wb_ack_o != wb_err_o)
      else $error("bus request not answered in next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_pulse: assert property (wb_err_o |=> !wb_err_o && !wb_ack_o)
      else $error("err longer than one cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   // Lock-loss outputs and interrupt
   a_pin_fastlock: assert property ($past(rst_n) |-> fastlock_en != lock_loss_pin_n)
      else $error("quick-acquisition not tied to lock-loss pin");
   a_reset_lost: assert property ($rose(rst_n) |-> !lock_loss_pin_n)
      else $error("lock loss not shown out of reset");
   a_irq_other: assert property (|other_irq |=> !irq_pin_n)
      else $error("irq pin not low for another source");
   a_irq_release: assert property ($rose(irq_pin_n) && $past(rst_n) |->
      $past(wb_ack_o && wb_we_i) || $past(|other_irq, 2))
      else $error("irq released without a write");
endmodule
bind llm_monitor llm_monitor_asserts #(.CNT_W(CNT_W), .IRQ_SRCS(IRQ_SRCS)) chk_u (
   .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .ref_edge(ref_edge),
   .fb_edge(fb_edge), .other_irq(other_irq), .lock_loss_pin_n(lock_loss_pin_n),
   .irq_pin_n(irq_pin_n), .fastlock_en(fastlock_en));
`default_nettype wire

// *** tb/llm_edge_model.sv ***
// Phase detector edge source: reference and feedback pulses
`timescale 1ns/1ps
`default_nettype none
module llm_edge_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [1:0] fb_mode,
   output logic ref_edge,
   output logic fb_edge
);
   logic [1:0] ph_reg;
   logic [7:0] cnt_reg;
   // Reference every fourth cycle; count of 250 reference edges
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ph_reg <= 2'h0;
         cnt_reg <= 8'h0;
      end else begin
         ph_reg <= ph_reg + 2'h1;
         if (ph_reg == 2'h3) cnt_reg <= (cnt_reg == 8'hf9) ? 8'h0 : cnt_reg + 8'h1;
      end
   end
   // Mode 0 equal, 1 four times faster, 2 one edge lost per 250
   assign ref_edge = rst_n && ph_reg == 2'h3;
   assign fb_edge = rst_n && (fb_mode == 2'h1 || (ref_edge && !(fb_mode == 2'h2 && cnt_reg == 8'h0)));
endmodule
`default_nettype wire

// *** tb/llm_monitor_tb.sv ***
// Self-checking bench of the lock-loss monitor
`timescale 1ns/1ps
`default_nettype none
module llm_monitor_tb;
   logic mclk, rst_n, cyc, stb, we, ack, err, oirq, pin_n, irq_n, fl, re, fe, lerr;
   logic [11:0] adr;
   logic [31:0] wd, rdat, q;
   logic [1:0] mode;
   int bad_count, checks, n;
   longint t0;
   llm_monitor dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .ref_edge(re), .fb_edge(fe), .other_irq(oirq),
      .lock_loss_pin_n(pin_n), .irq_pin_n(irq_n), .fastlock_en(fl));
   llm_edge_model peer (.mclk(mclk), .rst_n(rst_n), .fb_mode(mode), .ref_edge(re), .fb_edge(fe));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One classic cycle; answer taken at the rising edge that samples ack high
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge mclk);
         k++;
      end while (!(ack || err) && k < 20);
      if (!(ack || err)) bad_count++;
      q = rdat;
      lerr = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(posedge mclk);
      mode <= m;
   endtask
   task automatic wait_pin(input logic v, input int lim);
      n = 0;
      while (pin_n !== v && n < lim) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic t_regs;
      logic [11:0] a [8] = '{12'h038, 12'h064, 12'h248, 12'h278, 12'h280, 12'h288, 12'h2a4, 12'h2a8};
      logic [31:0] e [8] = '{32'h2, 32'h0, 32'h2, 32'h20, 32'h0, 32'h0, 32'h0, 32'h1};
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, a[i], 32'h0);
         chk("reset value", q, e[i]);
      end
      bus(1'b1, 12'h04c, 32'h0);
      bus(1'b0, 12'h04c, 32'h0);
      chk("sticky kept while lost", q, 32'h2);
      bus(1'b0, 12'h004, 32'h0);
      chk("unmapped err", {31'h0, lerr}, 32'h1);
      chk("pin at reset", {31'h0, pin_n}, 32'h0);
      bus(1'b1, 12'h2c0, 32'd500);
      bus(1'b1, 12'h278, 32'h60);
      bus(1'b1, 12'h248, 32'h0);
   endtask
   task automatic t_lock;
      wait_pin(1'b1, 9000);
      bus(1'b0, 12'h038, 32'h0);
      chk("live when locked", q, 32'h0);
      chk("fastlock off", {31'h0, fl}, 32'h0);
      chk("irq from sticky", {31'h0, irq_n}, 32'h0);
      bus(1'b1, 12'h04c, 32'h0);
      bus(1'b0, 12'h04c, 32'h0);
      chk("sticky cleared", q, 32'h0);
      repeat (3) @(negedge mclk);
      chk("irq released", {31'h0, irq_n}, 32'h1);
      oirq <= 1'b1;
      repeat (3) @(negedge mclk);
      chk("irq other source", {31'h0, irq_n}, 32'h0);
      oirq <= 1'b0;
   endtask
   task automatic t_loss;
      set_mode(2'h2);
      wait_pin(1'b0, 9000);
      t0 = $time;
      set_mode(2'h0);
      bus(1'b1, 12'h280, 32'ha0);
      bus(1'b1, 12'h288, 32'h2);
      bus(1'b0, 12'h038, 32'h0);
      chk("live when lost", q, 32'h2);
      chk("fastlock on", {31'h0, fl}, 32'h1);
      bus(1'b1, 12'h064, 32'h2);
      repeat (3) @(negedge mclk);
      chk("irq masked", {31'h0, irq_n}, 32'h1);
      bus(1'b1, 12'h064, 32'h0);
      repeat (3) @(negedge mclk);
      chk("irq unmasked", {31'h0, irq_n}, 32'h0);
      wait_pin(1'b1, 9000);
      chk("clear delay", {31'h0, (($time - t0) / 10) inside {[2100:2106]}}, 32'h1);
      bus(1'b1, 12'h288, 32'h0);
      bus(1'b0, 12'h04c, 32'h0);
      chk("sticky after relock", q, 32'h2);
      bus(1'b1, 12'h04c, 32'h0);
   endtask
   task automatic t_hyst;
      bus(1'b1, 12'h278, 32'h80);
      bus(1'b1, 12'h280, 32'h40);
      set_mode(2'h2);
      repeat (4100) @(negedge mclk);
      chk("below set stays locked", {31'h0, pin_n}, 32'h1);
      bus(1'b1, 12'h278, 32'h60);
      wait_pin(1'b0, 4100);
      chk("above set lost", {31'h0, pin_n}, 32'h0);
      bus(1'b1, 12'h278, 32'h80);
      repeat (4100) @(negedge mclk);
      chk("above clear stays lost", {31'h0, pin_n}, 32'h0);
      set_mode(2'h0);
      wait_pin(1'b1, 4100);
      chk("below clear locked", {31'h0, pin_n}, 32'h1);
   endtask
   task automatic t_fast;
      bus(1'b1, 12'h278, 32'h60);
      bus(1'b1, 12'h248, 32'h2);
      set_mode(2'h1);
      repeat (60) @(negedge mclk);
      chk("fast path asserts", {31'h0, pin_n}, 32'h0);
      set_mode(2'h0);
      wait_pin(1'b1, 9000);
      bus(1'b1, 12'h248, 32'h0);
      set_mode(2'h1);
      repeat (60) @(negedge mclk);
      chk("fast path off", {31'h0, pin_n}, 32'h1);
      set_mode(2'h0);
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      report_and_stop;
   end
   // Main sequence; host loads fixed settings as a tool would
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, oirq, lerr} = 5'h0;
      adr = 12'h0;
      wd = 32'h0;
      mode = 2'h0;
      bad_count = 0;
      checks = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs;
      t_lock;
      t_loss;
      t_hyst;
      t_fast;
      report_and_stop;
   end
endmodule
`default_nettype wire
